// file: include/ilc_params.svh
// constants of the interior lamp controller
`ifndef ILC_PARAMS_SVH
`define ILC_PARAMS_SVH
`define ILC_CLK_PERIOD_NS 10
`define ILC_TICK_PERIOD_NS 1000000
`define ILC_TICK_CYCLES (`ILC_TICK_PERIOD_NS / `ILC_CLK_PERIOD_NS)
`define ILC_AG_SHORT_MS 7500
`define ILC_AG_MID_MS 15000
`define ILC_AG_LONG_MS 30000
`define ILC_CUTOFF_MIN 20
`define ILC_CUTOFF_MS (`ILC_CUTOFF_MIN * 60 * 1000)
`define ILC_CTRL_OFS 12'h000
`define ILC_STAT_OFS 12'h004
`define ILC_CTRL_SEL_LSB 0
`define ILC_CTRL_CUTEN_BIT 2
`define ILC_SEL_RST 2'h2
`define ILC_CUTEN_RST 1'b1
`define ILC_SEL_OFF 2'h0
`define ILC_SEL_SHORT 2'h1
`define ILC_SEL_MID 2'h2
`endif

// file: include/ilc_pkg.sv
// types of the interior lamp controller
package ilc_pkg;
  typedef enum logic [1:0] {
    ILC_ENG_OFF = 2'h0,
    ILC_ENG_ACCESSORY_POSITION = 2'h1,
    ILC_ENG_ON = 2'h2
  } ilc_eng_t;

  typedef enum logic [2:0] {
    ILC_MAP_OFF = 3'h1,
    ILC_MAP_DOOR = 3'h2,
    ILC_MAP_GLOW = 3'h4
  } ilc_map_t;

  typedef struct packed {
    logic [1:0] door_open;
    logic trunk_open;
    logic mode_entry;
    ilc_eng_t eng_pos;
    logic [1:0] vanity_open;
    logic map_sw_press;
    logic doors_locked;
  } ilc_sw_t;

  typedef struct packed {
    logic lock_evt;
    logic unlock_evt;
    logic prox_evt;
  } ilc_can_t;

  typedef struct packed {
    logic map;
    logic [1:0] step;
    logic trunk;
    logic [1:0] vanity;
  } ilc_lamps_t;

  typedef struct packed {
    ilc_map_t map_st;
    logic manual;
    ilc_eng_t eng_prev;
    logic [1:0] door_prev;
    logic [15:0] ag_cnt;
    logic [23:0] cut_cnt;
    logic cut_trip;
    logic [16:0] tick_cnt;
    logic [1:0] sel;
    logic cut_en;
    ilc_lamps_t lamps;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ilc_state_t;
endpackage : ilc_pkg

// file: rtl/ilc_top.sv
// interior lamp controller with apb register access
// Overview of operation
// R1 - entry mode: map lamp lights when a side door (not trunk) opens
// R2 - after a trigger map lamp stays lit for afterglow time, then off
// R3 - entry mode: a door closing after opening starts the afterglow
// R4 - entry mode: unlock event lights map lamp and starts afterglow
// R5 - entry mode: proximity event while locked lights lamp, starts afterglow
// R6 - engine switch leaving off for accessory or on kills map lamp at once
// R7 - a lock event kills the map lamp at once
// R8 - afterglow selectable off, 7.5, 15 or 30 s; 15 s after reset
// R9 - each step lamp follows its own door open state
// R10 - trunk lamp follows the trunk open state
// R11 - engine off, door lighting on 20 min: force it off if enabled
// R12 - ajar cutoff enable bit, set after reset
// R13 - manual push switch toggles the map lamp independently
// R14 - each vanity lamp lit while its mirror lid is open
// R15 - extinguish beats a same-cycle turn-on trigger
`timescale 1ns/1ns
`include "ilc_params.svh"
module ilc_top #(
  parameter int unsigned TICK_CYC = `ILC_TICK_CYCLES,
  parameter int unsigned AG_SHORT_MS = `ILC_AG_SHORT_MS,
  parameter int unsigned AG_MID_MS = `ILC_AG_MID_MS,
  parameter int unsigned AG_LONG_MS = `ILC_AG_LONG_MS,
  parameter int unsigned CUTOFF_MS = `ILC_CUTOFF_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // switches and keyless events
  input wire ilc_pkg::ilc_sw_t sw,
  input wire ilc_pkg::ilc_can_t can,
  // lamp drives
  output ilc_pkg::ilc_lamps_t lamps
);

  ilc_pkg::ilc_state_t s_r;
  ilc_pkg::ilc_state_t s_nxt;

  logic tick;
  logic ext;
  logic eng_up;
  logic door_rise;
  logic door_fall;
  logic any_door;
  logic glow_trig;
  logic lit_linked;
  logic wr_ctrl;
  logic [15:0] ag_lim;

  // afterglow length in ms for the selected setting
  function automatic logic [15:0] ag_limit(input logic [1:0] sel);
    logic [15:0] v;
    v = 16'(AG_LONG_MS);
    case (sel)
      `ILC_SEL_OFF: v = 16'h0000;
      `ILC_SEL_SHORT: v = 16'(AG_SHORT_MS);
      `ILC_SEL_MID: v = 16'(AG_MID_MS);
      default: v = 16'(AG_LONG_MS);
    endcase
    return v;
  endfunction : ag_limit

  always_comb begin
    s_nxt = s_r;
    tick = (s_r.tick_cnt == 17'(TICK_CYC - 1));
    s_nxt.tick_cnt = tick ? 17'h00000 : s_r.tick_cnt + 17'h00001;
    s_nxt.eng_prev = sw.eng_pos;
    s_nxt.door_prev = sw.door_open;
    any_door = |sw.door_open;
    door_rise = |(sw.door_open & ~s_r.door_prev);
    door_fall = |(~sw.door_open & s_r.door_prev);
    // level of engine switch alone would also block the manual switch
    eng_up = (s_r.eng_prev == ilc_pkg::ILC_ENG_OFF) &&
      (sw.eng_pos != ilc_pkg::ILC_ENG_OFF); // [R6]
    ext = can.lock_evt | eng_up; // [R7]
    glow_trig = door_fall | can.unlock_evt | // [R3] [R4]
      (can.prox_evt & sw.doors_locked); // [R5]
    ag_lim = ag_limit(s_r.sel);
    wr_ctrl = psel && penable && s_r.pready && pwrite &&
      (paddr == `ILC_CTRL_OFS);

    // map lamp, extinguish first
    if (ext) begin
      s_nxt.map_st = ilc_pkg::ILC_MAP_OFF; // [R6] [R7] [R15]
      s_nxt.manual = 1'b0;
    end else begin
      if (sw.map_sw_press) begin
        s_nxt.manual = ~s_r.manual; // [R13]
      end
      if (!sw.mode_entry) begin
        s_nxt.map_st = ilc_pkg::ILC_MAP_OFF;
      end else if (door_rise) begin
        s_nxt.map_st = ilc_pkg::ILC_MAP_DOOR; // [R1]
      end else if (glow_trig && !any_door) begin
        s_nxt.ag_cnt = 16'h0000;
        if (s_r.sel == `ILC_SEL_OFF) begin
          s_nxt.map_st = ilc_pkg::ILC_MAP_OFF; // [R8]
        end else begin
          s_nxt.map_st = ilc_pkg::ILC_MAP_GLOW; // [R3] [R4] [R5]
        end
      end else begin
        case (s_r.map_st)
          ilc_pkg::ILC_MAP_OFF: begin
            s_nxt.map_st = ilc_pkg::ILC_MAP_OFF;
          end
          ilc_pkg::ILC_MAP_DOOR: begin
            // stays lit while some door is still open
            s_nxt.map_st = any_door ? ilc_pkg::ILC_MAP_DOOR : ilc_pkg::ILC_MAP_OFF;
          end
          ilc_pkg::ILC_MAP_GLOW: begin
            if (tick) begin
              if (s_r.ag_cnt >= ag_lim - 16'h0001) begin
                s_nxt.map_st = ilc_pkg::ILC_MAP_OFF; // [R2]
              end else begin
                s_nxt.ag_cnt = s_r.ag_cnt + 16'h0001;
              end
            end
          end
          default: begin
            s_nxt.map_st = ilc_pkg::ILC_MAP_OFF;
          end
        endcase
      end
    end

    // ajar cutoff; tripped state holds until the lighting cause goes away, the engine switch leaves off or cut_en clears
    lit_linked = (s_r.map_st != ilc_pkg::ILC_MAP_OFF) | any_door | sw.trunk_open;
    if (!s_r.cut_en || !lit_linked ||
        (sw.eng_pos != ilc_pkg::ILC_ENG_OFF)) begin
      s_nxt.cut_cnt = 24'h000000;
      s_nxt.cut_trip = 1'b0;
    end else if (tick && !s_r.cut_trip) begin
      if (s_r.cut_cnt == 24'(CUTOFF_MS - 1)) begin
        s_nxt.cut_trip = 1'b1; // [R11]
      end else begin
        s_nxt.cut_cnt = s_r.cut_cnt + 24'h000001;
      end
    end
    if (s_nxt.cut_trip) begin
      s_nxt.map_st = ilc_pkg::ILC_MAP_OFF; // [R11]
    end

    s_nxt.lamps.map = s_nxt.manual | (s_nxt.map_st != ilc_pkg::ILC_MAP_OFF);
    s_nxt.lamps.step = sw.door_open & {2{~s_nxt.cut_trip}}; // [R9] [R11]
    s_nxt.lamps.trunk = sw.trunk_open & ~s_nxt.cut_trip; // [R10] [R11]
    s_nxt.lamps.vanity = sw.vanity_open; // [R14]

    // apb: no wait state, answer registered in the setup cycle
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      if (paddr == `ILC_CTRL_OFS) begin
        s_nxt.prdata[`ILC_CTRL_SEL_LSB +: 2] = s_r.sel;
        s_nxt.prdata[`ILC_CTRL_CUTEN_BIT] = s_r.cut_en;
      end else if (paddr == `ILC_STAT_OFS) begin
        s_nxt.prdata[7:0] = {s_r.cut_trip,
          s_r.map_st == ilc_pkg::ILC_MAP_GLOW, s_r.lamps};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (wr_ctrl) begin
      s_nxt.sel = pwdata[`ILC_CTRL_SEL_LSB +: 2]; // [R8]
      s_nxt.cut_en = pwdata[`ILC_CTRL_CUTEN_BIT]; // [R12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{
        map_st: ilc_pkg::ILC_MAP_OFF,
        manual: 1'b0,
        eng_prev: ilc_pkg::ILC_ENG_OFF,
        door_prev: 2'h0,
        ag_cnt: 16'h0000,
        cut_cnt: 24'h000000,
        cut_trip: 1'b0,
        tick_cnt: 17'h00000,
        sel: `ILC_SEL_RST, // [R8]
        cut_en: `ILC_CUTEN_RST, // [R12]
        lamps: '0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0000_0000
      };
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign prdata = s_r.prdata;
  assign lamps = s_r.lamps;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence lock_seen;
    ce && can.lock_evt;
  endsequence

  sequence eng_rise;
    ce && (sw.eng_pos != ilc_pkg::ILC_ENG_OFF) &&
      (s_r.eng_prev == ilc_pkg::ILC_ENG_OFF);
  endsequence

  sequence glow_expiry;
    ce && tick && (s_r.map_st == ilc_pkg::ILC_MAP_GLOW) &&
      (s_r.ag_cnt >= ag_lim - 16'h0001) && !door_rise && !glow_trig;
  endsequence

  lock_kills_map_a: assert property ( // [R7]
    lock_seen |=> !lamps.map && (s_r.map_st == ilc_pkg::ILC_MAP_OFF))
    else $error("map lamp lit after lock event");

  eng_kills_map_a: assert property ( // [R6]
    eng_rise |=> !lamps.map)
    else $error("map lamp lit after engine switch left off");

  glow_ends_a: assert property ( // [R2]
    glow_expiry |=> (s_r.map_st == ilc_pkg::ILC_MAP_OFF))
    else $error("afterglow did not end at its limit");

  door_lights_map_a: assert property ( // [R1]
    ce && sw.mode_entry && door_rise && !ext && !s_nxt.cut_trip
    |=> lamps.map && (s_r.map_st == ilc_pkg::ILC_MAP_DOOR))
    else $error("map lamp not lit on door opening");

  unlock_glow_a: assert property ( // [R4]
    ce && sw.mode_entry && can.unlock_evt && !ext && !door_rise &&
    !any_door && (s_r.sel != `ILC_SEL_OFF) && !s_nxt.cut_trip
    |=> (s_r.map_st == ilc_pkg::ILC_MAP_GLOW) && (s_r.ag_cnt == 16'h0000))
    else $error("unlock did not start afterglow");

  ext_priority_a: assert property ( // [R15]
    ce && ext && (door_rise || glow_trig || sw.map_sw_press)
    |=> !lamps.map)
    else $error("trigger won over extinguish");

  step_follow_a: assert property ( // [R9]
    ce && !s_nxt.cut_trip |=> lamps.step == $past(sw.door_open))
    else $error("step lamp does not follow its door");

  trunk_follow_a: assert property ( // [R10]
    ce && !s_nxt.cut_trip |=> lamps.trunk == $past(sw.trunk_open))
    else $error("trunk lamp does not follow trunk");

  vanity_follow_a: assert property ( // [R14]
    ce |=> lamps.vanity == $past(sw.vanity_open))
    else $error("vanity lamp does not follow lid");

  cutoff_dark_a: assert property ( // [R11]
    s_r.cut_trip |-> !lamps.trunk && (lamps.step == 2'h0) &&
      (s_r.map_st == ilc_pkg::ILC_MAP_OFF))
    else $error("door lighting on while cut off");

  cutoff_enable_a: assert property ( // [R12]
    ce && !s_r.cut_en |=> !s_r.cut_trip)
    else $error("cutoff tripped while disabled");

  manual_toggle_a: assert property ( // [R13]
    ce && sw.map_sw_press && !ext |=> s_r.manual != $past(s_r.manual))
    else $error("manual switch did not toggle");

  ctrl_write_a: assert property ( // [R8]
    ce && wr_ctrl |=> s_r.sel == $past(pwdata[1:0]))
    else $error("afterglow setting not written");

  // a closed door with no door left open is the afterglow trigger
  sequence close_seen;
    ce && sw.mode_entry && door_fall && !any_door && !ext && !s_nxt.cut_trip;
  endsequence

  close_glow_a: assert property ( // [R3]
    close_seen ##0 (s_r.sel != `ILC_SEL_OFF)
    |=> (s_r.map_st == ilc_pkg::ILC_MAP_GLOW) && (s_r.ag_cnt == 16'h0000))
    else $error("door close did not start afterglow");

  prox_glow_a: assert property ( // [R5]
    ce && sw.mode_entry && can.prox_evt && sw.doors_locked && !ext && !any_door &&
    (s_r.sel != `ILC_SEL_OFF) && !s_nxt.cut_trip
    |=> (s_r.map_st == ilc_pkg::ILC_MAP_GLOW))
    else $error("proximity while locked did not start afterglow");

  off_setting_a: assert property ( // [R8]
    ce && sw.mode_entry && glow_trig && !ext && !any_door && (s_r.sel == `ILC_SEL_OFF)
    |=> (s_r.map_st == ilc_pkg::ILC_MAP_OFF))
    else $error("afterglow ran with setting off");

  // between ticks nothing but an extinguish, a new trigger, leaving entry mode or the cutoff may end the glow
  glow_holds_a: assert property ( // [R2]
    ce && (s_r.map_st == ilc_pkg::ILC_MAP_GLOW) && !tick && sw.mode_entry && !ext &&
    !door_rise && !glow_trig && !s_nxt.cut_trip |=> (s_r.map_st == ilc_pkg::ILC_MAP_GLOW))
    else $error("afterglow ended between ticks");

  cut_trip_a: assert property ( // [R11]
    ce && tick && s_r.cut_en && lit_linked && (sw.eng_pos == ilc_pkg::ILC_ENG_OFF) &&
    !s_r.cut_trip && (s_r.cut_cnt == 24'(CUTOFF_MS - 1)) |=> s_r.cut_trip)
    else $error("ajar cutoff did not trip at its limit");

  cut_engine_a: assert property ( // [R11]
    ce && (sw.eng_pos != ilc_pkg::ILC_ENG_OFF) |=> !s_r.cut_trip)
    else $error("ajar cutoff tripped with engine switch not off");

  cuten_write_a: assert property ( // [R12]
    ce && wr_ctrl |=> s_r.cut_en == $past(pwdata[`ILC_CTRL_CUTEN_BIT]))
    else $error("cutoff enable not written");

  mode_off_a: assert property ( // [R1]
    ce && !sw.mode_entry && !s_nxt.manual |=> !lamps.map)
    else $error("map lamp lit outside entry mode without manual");

  apb_ready_a: assert property ( // [R8] [R12]
    ce && psel && !penable |=> pready)
    else $error("no ready in access phase");

  apb_pulse_a: assert property ( // [R8] [R12]
    ce && pready |=> !pready)
    else $error("ready held longer than one cycle");

  apb_err_a: assert property (
    ce && psel && !penable && (paddr != `ILC_CTRL_OFS) && (paddr != `ILC_STAT_OFS)
    |=> pslverr && (prdata == 32'h0000_0000))
    else $error("unmapped access not flagged");

  // clock enable low must freeze every bit of state, apb answer included
  freeze_a: assert property (
    !ce |=> $stable(s_r))
    else $error("state moved while clock enable low");

endmodule : ilc_top

// file: verif/ilc_keyless_model.sv
// keyless entry controller stand-in driving lock, unlock and proximity events
`timescale 1ns/1ns
module ilc_keyless_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event requests from the bench
  input wire logic lock_req,
  input wire logic unlock_req,
  input wire logic prox_req,
  // decoded event pulses toward the controller
  output ilc_pkg::ilc_can_t can
);
  // each request is registered into its event one cycle later; a request held high keeps its event high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can <= '0;
    end else begin
      can <= '{lock_evt: lock_req, unlock_evt: unlock_req, prox_evt: prox_req};
    end
  end
endmodule : ilc_keyless_model

// file: verif/interior_lamp_controller_tb.sv
// self-checking bench of the interior lamp controller
`timescale 1ns/1ns
module interior_lamp_controller_tb;
  localparam int TK = 4;
  localparam int CUT = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lk, ul, px, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ilc_pkg::ilc_sw_t sw;
  ilc_pkg::ilc_can_t can;
  ilc_pkg::ilc_lamps_t lamps;
  int miscompares = 0;
  int samples_checked = 0;
  int ms[4] = '{0, 3, 5, 8};

  // short tick and counts keep the run small; expectations scale from them
  ilc_top #(.TICK_CYC(TK), .AG_SHORT_MS(3), .AG_MID_MS(5), .AG_LONG_MS(8),
    .CUTOFF_MS(CUT)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sw(sw), .can(can), .lamps(lamps));
  ilc_keyless_model u_key (.pclk(pclk), .presetn(presetn), .lock_req(lk),
    .unlock_req(ul), .prox_req(px), .can(can));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task pulse(input logic l, input logic u, input logic p);
    @(posedge pclk);
    lk <= l;
    ul <= u;
    px <= p;
    @(posedge pclk);
    lk <= 1'b0;
    ul <= 1'b0;
    px <= 1'b0;
    cyc(2);
  endtask : pulse

  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0006);
    apb(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_regs

  task t_door;
    @(posedge pclk) sw.door_open <= 2'h1;
    cyc(1);
    chk(lamps, 32'h28);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h28);
    @(posedge pclk) sw.door_open <= 2'h0;
    cyc(1);
    chk(lamps, 32'h20);
    cyc(5 * TK + 6);
    chk(lamps, 32'h00);
    @(posedge pclk) sw.trunk_open <= 1'b1;
    cyc(1);
    chk(lamps, 32'h04);
    @(posedge pclk) sw.trunk_open <= 1'b0;
    cyc(1);
    chk(lamps, 32'h00);
  endtask : t_door

  task t_sel;
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, 12'h000, 32'h4 | s);
      pulse(1'b0, 1'b1, 1'b0);
      chk(lamps.map, 32'h1);
      cyc((ms[s] - 1) * TK - 2);
      chk(lamps.map, 32'h1);
      cyc(2 * TK + 4);
      chk(lamps.map, 32'h0);
    end
    apb(1'b1, 12'h000, 32'h4);
    pulse(1'b0, 1'b1, 1'b0);
    chk(lamps.map, 32'h0);
    apb(1'b1, 12'h000, 32'h6);
  endtask : t_sel

  task t_kill;
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    chk(lamps.map, 32'h0);
    @(posedge pclk) sw.doors_locked <= 1'b1;
    pulse(1'b0, 1'b0, 1'b1);
    chk(lamps.map, 32'h1);
    @(posedge pclk) sw.eng_pos <= ilc_pkg::ILC_ENG_ACCESSORY_POSITION;
    cyc(1);
    chk(lamps.map, 32'h0);
    @(posedge pclk) sw.eng_pos <= ilc_pkg::ILC_ENG_OFF;
    pulse(1'b1, 1'b1, 1'b0);
    chk(lamps.map, 32'h0);
    @(posedge pclk) sw.doors_locked <= 1'b0;
  endtask : t_kill

  task t_manual;
    @(posedge pclk) sw.mode_entry <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk) sw.map_sw_press <= 1'b1;
      @(posedge pclk) sw.map_sw_press <= 1'b0;
      cyc(1);
      chk(lamps.map, 32'(i == 0));
    end
    @(posedge pclk) sw.vanity_open <= 2'h2;
    cyc(2);
    chk(lamps.vanity, 32'h2);
    @(posedge pclk);
    sw.vanity_open <= 2'h0;
    sw.mode_entry <= 1'b1;
  endtask : t_manual

  task t_cut;
    @(posedge pclk) sw.door_open <= 2'h2;
    cyc((CUT - 1) * TK - 2);
    chk(lamps, 32'h30);
    cyc(2 * TK + 4);
    chk(lamps, 32'h00);
    @(posedge pclk) sw.door_open <= 2'h0;
    cyc(30);
    apb(1'b1, 12'h000, 32'h2);
    @(posedge pclk) sw.door_open <= 2'h2;
    cyc(CUT * TK + 8);
    chk(lamps.step, 32'h2);
    @(posedge pclk) sw.door_open <= 2'h0;
  endtask : t_cut

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, lk, ul, px} = '0;
    paddr = '0;
    pwdata = '0;
    sw = '0;
    sw.mode_entry = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_door();
    t_sel();
    t_kill();
    t_manual();
    t_cut();
    print_verdict();
  end
endmodule : interior_lamp_controller_tb
